// ===== rtl/touch_map_pkg.sv
package touch_map_pkg;
  // word addresses of the map, bank 1
  localparam logic [9:0] ADDR_SETUP     = 10'h000;
  localparam logic [9:0] ADDR_CAL       = 10'h001;
  localparam logic [9:0] ADDR_IRQ_EN    = 10'h005;
  localparam logic [9:0] ADDR_IRQ_STAT  = 10'h008;
  localparam logic [9:0] ADDR_CONV      = 10'h00B;
  localparam logic [9:0] ADDR_PART_ID   = 10'h017;
  localparam logic [9:0] ADDR_PROX      = 10'h042;
  // bank 2 and bank 3 bases and per-stage strides
  localparam logic [9:0] ADDR_CFG       = 10'h080;
  localparam logic [9:0] ADDR_RES       = 10'h0E0;
  localparam logic [9:0] ADDR_MAX       = 10'h3FF;
  localparam int         NUM_CAL        = 4;
  localparam int         NUM_IRQ_EN     = 3;
  localparam int         NUM_IRQ_STAT   = 3;
  localparam int         NUM_CONV       = 12;
  localparam int         NUM_STAGES     = 12;
  localparam int         CFG_STRIDE     = 8;
  localparam int         RES_STRIDE     = 36;
  localparam int         NUM_CFG        = NUM_STAGES * CFG_STRIDE;
  localparam int         NUM_RES        = NUM_STAGES * RES_STRIDE;
  // reset values and fields of bank 1
  localparam logic [15:0] SETUP_RST     = 16'h0000;
  localparam logic [15:0] BANK1_RST     = 16'h0000;
  localparam int          SETUP_SWRST_BIT = 10;
  // arbitrary identification value, not tied to any real part
  localparam logic [15:0] PART_ID_VAL   = 16'h5A01;
endpackage

// ===== rtl/touch_decode_if.sv
`timescale 1ns/1ps
interface touch_decode_if;
  logic [9:0] addr;
  logic       sel_setup;
  logic       sel_cal;
  logic       sel_ien;
  logic       sel_istat;
  logic       sel_conv;
  logic       sel_id;
  logic       sel_prox;
  logic       sel_cfg;
  logic       sel_res;
  logic       gap;
  logic [8:0] index;
  modport requester (output addr, input sel_setup, sel_cal, sel_ien, sel_istat, sel_conv,
                     input sel_id, sel_prox, sel_cfg, sel_res, gap, index);
  modport decoder   (input addr, output sel_setup, sel_cal, sel_ien, sel_istat, sel_conv,
                     output sel_id, sel_prox, sel_cfg, sel_res, gap, index);
endinterface

// ===== rtl/touch_addr_decode.sv
`timescale 1ns/1ps
module touch_addr_decode (
  // address in, selects out
  touch_decode_if.decoder dec
);
  // half-open range test, used for every multi-word region of the map
  function automatic logic in_range(input logic [9:0] a, input logic [9:0] base,
                                    input int count);
    logic [10:0] top;
    top = 11'(base) + 11'(count);
    return (a >= base) && (11'(a) < top);
  endfunction

  // one select per region; anything left over is a gap
  assign dec.sel_setup = (dec.addr == touch_map_pkg::ADDR_SETUP);
  assign dec.sel_cal   = in_range(dec.addr, touch_map_pkg::ADDR_CAL, touch_map_pkg::NUM_CAL);
  assign dec.sel_ien   = in_range(dec.addr, touch_map_pkg::ADDR_IRQ_EN,
                                  touch_map_pkg::NUM_IRQ_EN);
  assign dec.sel_istat = in_range(dec.addr, touch_map_pkg::ADDR_IRQ_STAT,
                                  touch_map_pkg::NUM_IRQ_STAT);
  assign dec.sel_conv  = in_range(dec.addr, touch_map_pkg::ADDR_CONV, touch_map_pkg::NUM_CONV);
  assign dec.sel_id    = (dec.addr == touch_map_pkg::ADDR_PART_ID);
  assign dec.sel_prox  = (dec.addr == touch_map_pkg::ADDR_PROX);
  assign dec.sel_cfg   = in_range(dec.addr, touch_map_pkg::ADDR_CFG, touch_map_pkg::NUM_CFG);
  assign dec.sel_res   = in_range(dec.addr, touch_map_pkg::ADDR_RES, touch_map_pkg::NUM_RES);
  assign dec.gap       = ~(dec.sel_setup | dec.sel_cal | dec.sel_ien | dec.sel_istat |
                           dec.sel_conv | dec.sel_id | dec.sel_prox | dec.sel_cfg |
                           dec.sel_res);                     // see RULE1
  // index within the selected region; stride-8 and stride-36 stages fall out of it
  assign dec.index = dec.sel_res  ? 9'(dec.addr - touch_map_pkg::ADDR_RES)    // see RULE9
                   : dec.sel_cfg  ? 9'(dec.addr - touch_map_pkg::ADDR_CFG)    // see RULE6
                   : dec.sel_conv ? 9'(dec.addr - touch_map_pkg::ADDR_CONV)
                   : dec.sel_istat ? 9'(dec.addr - touch_map_pkg::ADDR_IRQ_STAT)
                   : dec.sel_ien  ? 9'(dec.addr - touch_map_pkg::ADDR_IRQ_EN)
                   : dec.sel_cal  ? 9'(dec.addr - touch_map_pkg::ADDR_CAL)
                   : 9'h000;
endmodule // touch_addr_decode

// ===== rtl/touch_cdc_register_map.sv
// Operation
// RULE1: map split into three banks
// RULE2: bank one holds control, status, data, identity
// RULE3: twelve conversion words from 0x00B
// RULE4: host avoids undefined gaps up to 0x7F0
// RULE5: bank two holds per-stage input setup
// RULE6: eight config words per stage, from 0x080
// RULE7: host configures bank two before trusting results
// RULE8: banks two and three have no reset
// RULE9: thirty-six result words per stage, from 0xE0
// RULE10: results refresh at each sequence end
// RULE11: host may read result registers
// RULE12: sixteen-bit registers, upper byte written first
// RULE13: gap accesses change nothing, read zero
`timescale 1ns/1ps
module touch_cdc_register_map (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // host side, byte stream from the serial front end
  input  wire logic        addr_load,
  input  wire logic [9:0]  addr_in,
  input  wire logic        wr_valid,
  input  wire logic [7:0]  wr_byte,
  input  wire logic        rd_req,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  // conversion engine side
  input  wire logic        seq_done,
  input  wire logic [191:0] conv_in,
  input  wire logic        res_we,
  input  wire logic [8:0]  res_idx,
  input  wire logic [15:0] res_in,
  input  wire logic [47:0] stat_set,
  input  wire logic [15:0] prox_in,
  input  wire logic [6:0]  cfg_idx,
  output logic [15:0]      cfg_out,
  output logic [15:0]      setup_out,
  output logic [63:0]      cal_out,
  output logic [47:0]      irq_en_out
);
  logic [9:0]  ptr_r;
  logic        phase_r;
  logic [7:0]  hi_r;
  logic [15:0] setup_r;
  logic [15:0] cal_r   [touch_map_pkg::NUM_CAL];
  logic [15:0] ien_r   [touch_map_pkg::NUM_IRQ_EN];
  logic [15:0] istat_r [touch_map_pkg::NUM_IRQ_STAT];
  logic [15:0] conv_r  [touch_map_pkg::NUM_CONV];
  logic [15:0] cfg_mem [touch_map_pkg::NUM_CFG];
  logic [15:0] res_mem [touch_map_pkg::NUM_RES];
  logic [15:0] rd_nxt;
  logic [15:0] wr_word;
  logic        commit;
  logic        swrst;
  logic        ptr_at_max;
  touch_decode_if dec ();

  touch_addr_decode u_dec (
    .dec (dec)
  );

  // the pointer drives decode; it stops at the top and never wraps
  assign dec.addr   = ptr_r;
  assign ptr_at_max = (ptr_r == touch_map_pkg::ADDR_MAX);
  assign wr_word    = {hi_r, wr_byte};                          // see RULE12
  assign commit     = ce & wr_valid & phase_r & ~addr_load;     // see RULE12
  // soft reset only acts when the write really lands on the setup word
  assign swrst      = commit & dec.sel_setup & wr_word[touch_map_pkg::SETUP_SWRST_BIT];

  // read mux: gaps and unmapped words read zero
  assign rd_nxt = dec.sel_setup ? setup_r
                : dec.sel_cal   ? cal_r[dec.index[1:0]]
                : dec.sel_ien   ? ien_r[dec.index[1:0]]
                : dec.sel_istat ? istat_r[dec.index[1:0]]
                : dec.sel_conv  ? conv_r[dec.index[3:0]]                  // see RULE3
                : dec.sel_id    ? touch_map_pkg::PART_ID_VAL              // see RULE2
                : dec.sel_prox  ? prox_in
                : dec.sel_cfg   ? cfg_mem[dec.index[6:0]]                 // see RULE5
                : dec.sel_res   ? res_mem[dec.index]                      // see RULE11
                : 16'h0000;                                               // see RULE13

  // address pointer and byte pairing
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ptr_r   <= 10'h000;
      phase_r <= 1'b0;
      hi_r    <= 8'h00;
    end
    else if (ce)
    begin
      if (addr_load)
      begin
        ptr_r   <= addr_in;
        phase_r <= 1'b0;
      end
      else
      begin
        if (wr_valid)
          phase_r <= ~phase_r;
        if (wr_valid && !phase_r)
          hi_r <= wr_byte;                                        // see RULE12
        if ((commit || rd_req) && !ptr_at_max)
          ptr_r <= ptr_r + 10'h001;
      end
    end
  end

  // read data is registered, one cycle after the request
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rd_valid <= 1'b0;
      rd_data  <= 16'h0000;
    end
    else if (ce)
    begin
      rd_valid <= rd_req & ~addr_load;
      if (rd_req && !addr_load)
        rd_data <= rd_nxt;
    end
  end

  // setup word; soft reset self-clears and returns the setup, calibration, enable and status words to defaults
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || (ce && swrst))
      setup_r <= touch_map_pkg::SETUP_RST;
    else if (commit && dec.sel_setup)
      setup_r <= wr_word;                                          // see RULE2
  end

  // calibration and interrupt enable words, writable
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || (ce && swrst))
    begin
      for (int i = 0; i < touch_map_pkg::NUM_CAL; i++)
        cal_r[i] <= touch_map_pkg::BANK1_RST;
      for (int i = 0; i < touch_map_pkg::NUM_IRQ_EN; i++)
        ien_r[i] <= touch_map_pkg::BANK1_RST;
    end
    else if (commit)
    begin
      if (dec.sel_cal)
        cal_r[dec.index[1:0]] <= wr_word;
      if (dec.sel_ien)
        ien_r[dec.index[1:0]] <= wr_word;
    end
  end

  // sticky status: engine sets, host read clears, and a set in the same cycle wins
  generate
    for (genvar s = 0; s < touch_map_pkg::NUM_IRQ_STAT; s++)
    begin : g_stat
      logic rd_clr;
      assign rd_clr = ce & rd_req & ~addr_load & dec.sel_istat & (dec.index[1:0] == 2'(s));
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst || (ce && swrst))
          istat_r[s] <= touch_map_pkg::BANK1_RST;
        else if (ce)
          istat_r[s] <= (istat_r[s] & ~{16{rd_clr}}) | stat_set[s*16 +: 16];  // see RULE2
      end
    end
  endgenerate

  // conversion words load together when a sequence ends
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < touch_map_pkg::NUM_CONV; i++)
        conv_r[i] <= touch_map_pkg::BANK1_RST;
    end
    else if (ce && seq_done)
    begin
      for (int i = 0; i < touch_map_pkg::NUM_CONV; i++)
        conv_r[i] <= conv_in[i*16 +: 16];                           // see RULE3
    end
  end

  // bank two: no reset on purpose, contents are garbage until the host loads them
  always_ff @(posedge ref_clk)
  begin
    if (ce && commit && dec.sel_cfg)
      cfg_mem[dec.index[6:0]] <= wr_word;                          // see RULE8
  end

  // bank three: engine-written only, host access is read-only
  always_ff @(posedge ref_clk)
  begin
    if (ce && res_we && (res_idx < 9'(touch_map_pkg::NUM_RES)))
      res_mem[res_idx] <= res_in;                                  // see RULE10
  end

  // engine-facing copies of the control words
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      cfg_out <= 16'h0000;
    else if (ce)
      cfg_out <= cfg_mem[cfg_idx];                                 // see RULE7
  end

  assign setup_out  = setup_r;
  assign cal_out    = {cal_r[3], cal_r[2], cal_r[1], cal_r[0]};
  assign irq_en_out = {ien_r[2], ien_r[1], ien_r[0]};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_hi_byte;
    ce && wr_valid && !phase_r && !addr_load && dec.sel_cal;
  endsequence
  sequence s_lo_byte;
    ce && wr_valid && !addr_load;
  endsequence

  AST_RD_ONE_CYCLE: assert property (ce && rd_req && !addr_load |=> rd_valid) // see RULE11
    else $error("read answer not one cycle after request");
  AST_GAP_READS_ZERO: assert property (ce && rd_req && !addr_load && dec.gap |=> rd_data == 16'h0000) // see RULE13
    else $error("gap read returned nonzero");
  AST_GAP_NO_WRITE: assert property (commit && dec.gap |=> $stable(setup_r) && $stable(cal_r[0])) // see RULE13
    else $error("gap write disturbed a register");
  AST_BYTE_PAIR: assert property (s_hi_byte ##1 s_lo_byte |=>
      cal_r[$past(dec.index[1:0], 2)] == {$past(wr_byte, 2), $past(wr_byte)}) // see RULE12
    else $error("byte pair not combined upper first");
  AST_PTR_STEP: assert property (commit && !ptr_at_max |=> ptr_r == $past(ptr_r) + 10'h001) // see RULE12
    else $error("pointer did not advance after word write");
  AST_CONV_LOAD: assert property (ce && seq_done |=> conv_r[11] == $past(conv_in[191:176])) // see RULE10
    else $error("conversion word not loaded at sequence end");
  AST_CONV_BASE: assert property (ptr_r == 10'h00B |-> dec.sel_conv && dec.index == 9'h000) // see RULE3
    else $error("conversion block base decode wrong");
  AST_CFG_STRIDE: assert property (ptr_r == 10'h088 |-> dec.sel_cfg && dec.index == 9'h008) // see RULE6
    else $error("second stage config not at stride eight");
  AST_RES_STRIDE: assert property (ptr_r == 10'h104 |-> dec.sel_res && dec.index == 9'h024) // see RULE9
    else $error("second stage results not at stride thirty-six");
  AST_BANKS: assert property (ptr_r == 10'h07F |-> dec.gap) // see RULE1
    else $error("space between banks one and two decoded");
  AST_STAT_SET_WINS: assert property (ce && stat_set[0] |=> istat_r[0][0]) // see RULE2
    else $error("status event lost");
endmodule // touch_cdc_register_map

// ===== verification/host_model.sv
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic        ref_clk,
  // requests toward the register map
  output logic             addr_load,
  output logic [9:0]       addr_in,
  output logic             wr_valid,
  output logic [7:0]       wr_byte,
  output logic             rd_req,
  // answers
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data
);
  // idle levels from time zero
  initial
  begin
    addr_load = 1'b0;
    addr_in   = 10'h000;
    wr_valid  = 1'b0;
    wr_byte   = 8'h00;
    rd_req    = 1'b0;
  end

  // load the pointer; gap addresses only when the bench asks
  task automatic point(input logic [9:0] a);
    @(posedge ref_clk);
    addr_load <= 1'b1;
    addr_in   <= a;
    @(posedge ref_clk);
    addr_load <= 1'b0;
    addr_in   <= ~a; // scrambled so nothing leans on a stale address
  endtask

  // whole words only, upper byte first
  task automatic write_word(input logic [9:0] a, input logic [15:0] d);
    point(a);
    wr_valid <= 1'b1;
    wr_byte  <= d[15:8];
    @(posedge ref_clk);
    wr_byte  <= d[7:0];
    @(posedge ref_clk);
    wr_valid <= 1'b0;
    wr_byte  <= ~d[7:0]; // released lane does not keep the last byte
  endtask

  // answer due one cycle after the request is taken; a missing one reads as unknown
  task automatic read_word(input logic [9:0] a, output logic [15:0] d);
    point(a);
    rd_req <= 1'b1;
    @(posedge ref_clk);
    rd_req <= 1'b0;
    #1;
    d = (rd_valid === 1'b1) ? rd_data : 16'hXXXX;
  endtask
endmodule // host_model

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic         ref_clk, sys_rst, ce, addr_load, wr_valid, rd_req, rd_valid, seq_done, res_we;
  logic [9:0]   addr_in;
  logic [7:0]   wr_byte;
  logic [15:0]  rd_data, res_in, prox_in, cfg_out, setup_out;
  logic [191:0] conv_in;
  logic [8:0]   res_idx;
  logic [47:0]  stat_set, irq_en_out;
  logic [6:0]   cfg_idx;
  logic [63:0]  cal_out;
  logic [9:0]   gaps [5] = '{10'h018, 10'h043, 10'h07F, 10'h290, 10'h3FF};
  int           err_count, total_checks;

  touch_cdc_register_map touch_cdc_register_map_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .addr_load(addr_load),
    .addr_in(addr_in), .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req),
    .rd_valid(rd_valid), .rd_data(rd_data), .seq_done(seq_done), .conv_in(conv_in),
    .res_we(res_we), .res_idx(res_idx), .res_in(res_in), .stat_set(stat_set),
    .prox_in(prox_in), .cfg_idx(cfg_idx), .cfg_out(cfg_out), .setup_out(setup_out),
    .cal_out(cal_out), .irq_en_out(irq_en_out));
  host_model host_model_inst (
    .ref_clk(ref_clk), .addr_load(addr_load), .addr_in(addr_in), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data));

  // 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_check(input logic [9:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host_model_inst.read_word(a, d);
    check16(d, exp);
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    host_model_inst.write_word(a, d);
  endtask

  task automatic print_verdict;
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // the sequence needs about 550 cycles; 20000 means a hang
  initial
  begin
    #200000;
    err_count++;
    print_verdict;
  end

  initial
  begin
    sys_rst = 1'b1;
    ce = 1'b1;
    seq_done = 1'b0;
    conv_in = '0;
    res_we = 1'b0;
    res_idx = 9'h000;
    res_in = 16'h0000;
    stat_set = '0;
    prox_in = 16'hA5C3;
    cfg_idx = 7'h00;
    err_count = 0;
    total_checks = 0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // bank one after reset, identity and live proximity
    rd_check(touch_map_pkg::ADDR_SETUP, 16'h0000);
    rd_check(touch_map_pkg::ADDR_PART_ID, touch_map_pkg::PART_ID_VAL);
    rd_check(touch_map_pkg::ADDR_PROX, 16'hA5C3);
    // whole configuration bank first, so results can be trusted
    for (int i = 0; i < touch_map_pkg::NUM_CFG; i++)
      wr(touch_map_pkg::ADDR_CFG + 10'(i), 16'hC000 + 16'(i));
    rd_check(10'h088, 16'hC008);
    rd_check(10'h0DF, 16'hC05F);
    @(posedge ref_clk);
    cfg_idx <= 7'h08;
    @(posedge ref_clk);
    #1;
    check16(cfg_out, 16'hC008);
    // write lands upper byte first
    wr(touch_map_pkg::ADDR_SETUP, 16'h00B2);
    rd_check(touch_map_pkg::ADDR_SETUP, 16'h00B2);
    check16(setup_out, 16'h00B2);
    // calibration word pairs its bytes upper first
    wr(touch_map_pkg::ADDR_CAL + 10'h001, 16'h3230);
    #1;
    check16(cal_out[31:16], 16'h3230);
    wr(touch_map_pkg::ADDR_PART_ID, 16'h1234);
    rd_check(touch_map_pkg::ADDR_PART_ID, touch_map_pkg::PART_ID_VAL);
    // twelve conversion words loaded at sequence end
    @(posedge ref_clk);
    seq_done <= 1'b1;
    for (int i = 0; i < 12; i++)
      conv_in[16*i +: 16] <= 16'hD000 + 16'(i);
    @(posedge ref_clk);
    seq_done <= 1'b0;
    for (int i = 0; i < 12; i++)
      rd_check(touch_map_pkg::ADDR_CONV + 10'(i), 16'hD000 + 16'(i));
    // enable low freezes the words even when a sequence ends
    @(posedge ref_clk);
    ce <= 1'b0;
    seq_done <= 1'b1;
    conv_in <= '1;
    @(posedge ref_clk);
    ce <= 1'b1;
    seq_done <= 1'b0;
    rd_check(touch_map_pkg::ADDR_CONV, 16'hD000);
    // engine fills result words at the stage boundaries
    @(posedge ref_clk);
    res_we <= 1'b1;
    res_in <= 16'hE0E0;
    @(posedge ref_clk);
    res_idx <= 9'd36;
    res_in <= 16'hE104;
    @(posedge ref_clk);
    res_idx <= 9'd35;
    res_in <= 16'hE035;
    @(posedge ref_clk);
    res_we <= 1'b0;
    rd_check(10'h0E0, 16'hE0E0);
    rd_check(10'h104, 16'hE104);
    rd_check(10'h103, 16'hE035);
    wr(10'h0E0, 16'h1111);
    rd_check(10'h0E0, 16'hE0E0);
    // gaps swallow writes and read as zero
    foreach (gaps[g])
    begin
      wr(gaps[g], 16'hFFFF);
      rd_check(gaps[g], 16'h0000);
    end
    rd_check(touch_map_pkg::ADDR_SETUP, 16'h00B2);
    // status returns the set bits, then clears on read
    @(posedge ref_clk);
    stat_set <= 48'h0000_0000_0009;
    @(posedge ref_clk);
    stat_set <= '0;
    rd_check(touch_map_pkg::ADDR_IRQ_STAT, 16'h0009);
    rd_check(touch_map_pkg::ADDR_IRQ_STAT, 16'h0000);
    // soft reset clears enables and setup
    wr(touch_map_pkg::ADDR_IRQ_EN, 16'h0FFF);
    // the word lands on the edge the task returns at; let it settle
    #1;
    check16(irq_en_out[15:0], 16'h0FFF);
    wr(touch_map_pkg::ADDR_SETUP, 16'h0400);
    rd_check(touch_map_pkg::ADDR_IRQ_EN, 16'h0000);
    rd_check(touch_map_pkg::ADDR_SETUP, 16'h0000);
    check16(cal_out[31:16], 16'h0000);
    print_verdict;
  end
endmodule // tb
